// File: verilog/path_alarm_monitor.sv
/*
 * High-order path alarm monitor: label, excess error, remote failure and
 * trace checks with an APB register file and one level interrupt.
 * Assumes the overhead extractor runs on pclk and presents strobed bytes.
 */
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module path_alarm_monitor
	import path_mon_pkg::*;
#(
	parameter int WINDOW = WINDOW_FRAMES
)
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic        c2_valid,
	input  wire logic [7:0]  c2_rx,
	input  wire logic        frame_tick,
	input  wire logic [3:0]  b3_err_inc,
	input  wire logic        j1_valid,
	input  wire logic        j1_start,
	input  wire logic [7:0]  j1_rx,
	input  wire logic        persist_fail,
	input  wire logic        rfi_rx,
	output var  logic [7:0]  tx_c2_label,
	output var  logic        link_down,
	output var  logic        protect_switch,
	output var  logic        path_remote_fail_ind_tx,
	output var  logic        tim_critical,
	output var  logic        tim_minor,
	output var  logic        irq
);

	function automatic logic is_pdi(input logic [7:0] v);
		return (v >= C2_PDI_LO) && (v <= C2_PDI_HI);
	endfunction : is_pdi

	function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
		return a[ADDR_W-1:0] == off && a[31:ADDR_W] == '0;
	endfunction : hit

	////////////////////////////////////////////////////////////////////////////
	// register bus

	logic [3:0]       ctrl_r;
	logic [7:0]       exp_c2_r;
	logic [15:0]      exc_thr_r;
	logic [N_EVT-1:0] int_stat_r;
	logic [N_EVT-1:0] int_mask_r;
	logic [7:0]       rx_c2_r;
	logic [15:0]      err_last_r;
	logic [N_EVT-1:0] alarm;
	logic [6:0]       alarm_rd;
	logic             acc;
	logic             wr_acc;
	logic             j1_hit;
	logic             mapped;
	logic [31:0]      rd_nxt;

	// one wait state: pready rises in the second access cycle
	assign acc    = psel && penable && !pready;
	assign wr_acc = psel && penable && pready && pwrite;
	assign j1_hit = paddr[31:ADDR_W] == '0 && paddr[ADDR_W-1:0] >= ADDR_J1_BASE
		&& paddr[ADDR_W-1:0] <= ADDR_J1_LAST && paddr[1:0] == 2'b00;

	always_comb begin
		rd_nxt = 32'h0000_0000;
		mapped = 1'b1;
		if (hit(paddr, ADDR_CTRL))          rd_nxt[3:0]       = ctrl_r;
		else if (hit(paddr, ADDR_EXP_C2))   rd_nxt[7:0]       = exp_c2_r;
		else if (hit(paddr, ADDR_EXC_THR))  rd_nxt[15:0]      = exc_thr_r;
		else if (hit(paddr, ADDR_ALARM))    rd_nxt[6:0]       = alarm_rd;
		else if (hit(paddr, ADDR_INT_STAT)) rd_nxt[N_EVT-1:0] = int_stat_r;
		else if (hit(paddr, ADDR_INT_MASK)) rd_nxt[N_EVT-1:0] = int_mask_r;
		else if (hit(paddr, ADDR_RX_C2))    rd_nxt[7:0]       = rx_c2_r;
		else if (hit(paddr, ADDR_ERR_CNT))  rd_nxt[15:0]      = err_last_r;
		else if (!j1_hit)                   mapped            = 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= acc;
			prdata  <= (acc && !pwrite) ? rd_nxt : 32'h0000_0000;
			pslverr <= acc && !mapped;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r     <= CTRL_RST;
			exp_c2_r   <= EXP_C2_RST;
			exc_thr_r  <= EXC_THR_RST;
			int_mask_r <= '0;
		end else if (wr_acc) begin
			if (hit(paddr, ADDR_CTRL))     ctrl_r     <= pwdata[3:0];
			if (hit(paddr, ADDR_EXP_C2))   exp_c2_r   <= pwdata[7:0];
			if (hit(paddr, ADDR_EXC_THR))  exc_thr_r  <= pwdata[15:0];
			if (hit(paddr, ADDR_INT_MASK)) int_mask_r <= pwdata[N_EVT-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// signal label check

	logic [7:0] exp_eff;
	logic [7:0] mode_label;
	logic       base_mis;
	logic       encap_r;
	logic       plm_r;

	assign mode_label = ctrl_r[CTRL_GFP_MODE] ? C2_GFP : C2_EQUIP_UNSPEC;
	assign exp_eff    = ctrl_r[CTRL_EXP_AUTO] ? mode_label : exp_c2_r;
	assign base_mis   = c2_rx != C2_UNEQUIPPED && !is_pdi(c2_rx) && c2_rx != exp_eff;

	// both flags are re-evaluated on every received label; encap_r stays low on the label after one that set plm_r
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_c2_r <= 8'h00;
			encap_r <= 1'b0;
			plm_r   <= 1'b0;
		end else if (c2_valid) begin
			rx_c2_r <= c2_rx;
			plm_r   <= base_mis && exp_eff != C2_EQUIP_UNSPEC
				&& c2_rx != C2_EQUIP_UNSPEC;
			encap_r <= base_mis && !plm_r
				&& (exp_eff == C2_EQUIP_UNSPEC || c2_rx == C2_EQUIP_UNSPEC);
		end else if (plm_r) begin
			encap_r <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_c2_label <= C2_EQUIP_UNSPEC;
			link_down   <= 1'b0;
		end else begin
			tx_c2_label <= mode_label;
			link_down   <= encap_r && ctrl_r[CTRL_LINK_TRIG];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// B3 excess error with hysteresis

	logic [15:0] win_cnt_r;
	logic [15:0] err_acc_r;
	logic [16:0] err_sum;
	logic [15:0] err_sat;
	logic [15:0] clr_thr;
	logic        win_end;
	logic        exc_r;

	assign win_end = frame_tick && win_cnt_r == 16'(WINDOW - 1);
	assign err_sum = {1'b0, err_acc_r} + {13'h0000, b3_err_inc};
	assign err_sat = err_sum[16] ? 16'hFFFF : err_sum[15:0];
	assign clr_thr = 16'(exc_thr_r / HYST_DIV);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			win_cnt_r  <= 16'h0000;
			err_acc_r  <= 16'h0000;
			err_last_r <= 16'h0000;
			exc_r      <= 1'b0;
		end else if (frame_tick) begin
			if (win_end) begin
				win_cnt_r  <= 16'h0000;
				err_acc_r  <= 16'h0000;
				err_last_r <= err_sat;
				if (!exc_r && err_sat >= exc_thr_r)
					exc_r <= 1'b1;
				else if (exc_r && err_sat <= clr_thr)
					exc_r <= 1'b0;
			end else begin
				win_cnt_r <= win_cnt_r + 16'h0001;
				err_acc_r <= err_sat;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// protection switch and remote failure

	logic rfi_in_r;
	logic sw_req;

	assign sw_req = exc_r || persist_fail;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			protect_switch          <= 1'b0;
			path_remote_fail_ind_tx <= 1'b0;
			rfi_in_r                <= 1'b0;
		end else begin
			protect_switch <= sw_req;
			// sent in the same cycle as protect_switch when persist_fail raises it; a switch from exc_r alone sends none
			path_remote_fail_ind_tx <= persist_fail;
			rfi_in_r <= rfi_rx;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// J1 trace check

	logic [J1_IDX_W-1:0] j1_idx_r;
	logic [J1_IDX_W-1:0] rd_idx;
	logic [7:0]          j1_d_r;
	logic [7:0]          exp_j1;
	logic                j1_v_r;
	logic                j1_last_r;
	logic                j1_bad_r;
	logic                tim_r;

	// the memory read is registered, so the received byte is delayed to meet it
	assign rd_idx = j1_start ? '0 : j1_idx_r;

	trace_mem u_trace_mem (
		.pclk    (pclk),
		.presetn (presetn),
		.wr_en   (wr_acc && j1_hit),
		.wr_addr (paddr[J1_IDX_W+1:2]),
		.wr_data (pwdata[7:0]),
		.rd_addr (rd_idx),
		.rd_data (exp_j1)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			j1_idx_r  <= '0;
			j1_d_r    <= 8'h00;
			j1_v_r    <= 1'b0;
			j1_last_r <= 1'b0;
		end else begin
			j1_v_r    <= j1_valid;
			j1_d_r    <= j1_rx;
			j1_last_r <= j1_valid && rd_idx == J1_IDX_W'(J1_LEN - 1);
			if (j1_valid)
				j1_idx_r <= rd_idx + 1'b1;
		end
	end

	// a whole trace is judged at once: any bad byte raises, a clean trace clears
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			j1_bad_r <= 1'b0;
			tim_r    <= 1'b0;
		end else if (j1_v_r) begin
			if (j1_last_r) begin
				tim_r    <= j1_bad_r || j1_d_r != exp_j1;
				j1_bad_r <= 1'b0;
			end else if (j1_d_r != exp_j1) begin
				j1_bad_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tim_critical <= 1'b0;
			tim_minor    <= 1'b0;
		end else begin
			tim_critical <= tim_r && ctrl_r[CTRL_TERMINATED];
			tim_minor    <= tim_r && !ctrl_r[CTRL_TERMINATED];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// alarm status and interrupt

	logic [N_EVT-1:0] alarm_d_r;

	assign alarm[AL_ENCAP]  = encap_r;
	assign alarm[AL_PLM]    = plm_r;
	assign alarm[AL_EXC]    = exc_r;
	assign alarm[AL_RFI_RX] = rfi_in_r;
	assign alarm[AL_TIM]    = tim_r;
	assign alarm_rd = {link_down, path_remote_fail_ind_tx, alarm};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			alarm_d_r <= '0;
		else
			alarm_d_r <= alarm;
	end

	// a rising alarm in the cycle of a clearing write still sets its bit
	for (genvar i = 0; i < N_EVT; i++) begin : g_stat
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn)
				int_stat_r[i] <= 1'b0;
			else if (alarm[i] && !alarm_d_r[i])
				int_stat_r[i] <= 1'b1;
			else if (wr_acc && hit(paddr, ADDR_INT_STAT) && pwdata[i])
				int_stat_r[i] <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(int_stat_r & int_mask_r);
	end

endmodule : path_alarm_monitor

`default_nettype wire

// File: verilog/path_mon_pkg.sv
/*
 * Constants for the high-order path alarm monitor: register map, field
 * positions, reset values, label codes and error window length.
 * Assumes byte addresses on a 32-bit APB, one register per aligned word.
 */
package path_mon_pkg;

	localparam int          ADDR_W          = 8;
	localparam logic [7:0]  ADDR_CTRL       = 8'h00;
	localparam logic [7:0]  ADDR_EXP_C2     = 8'h04;
	localparam logic [7:0]  ADDR_EXC_THR    = 8'h08;
	localparam logic [7:0]  ADDR_ALARM      = 8'h0C;
	localparam logic [7:0]  ADDR_INT_STAT   = 8'h10;
	localparam logic [7:0]  ADDR_INT_MASK   = 8'h14;
	localparam logic [7:0]  ADDR_RX_C2      = 8'h18;
	localparam logic [7:0]  ADDR_ERR_CNT    = 8'h1C;
	localparam logic [7:0]  ADDR_J1_BASE    = 8'h40;
	localparam logic [7:0]  ADDR_J1_LAST    = 8'h7C;

	// control register fields
	localparam int          CTRL_LINK_TRIG  = 0;
	localparam int          CTRL_GFP_MODE   = 1;
	localparam int          CTRL_EXP_AUTO   = 2;
	localparam int          CTRL_TERMINATED = 3;
	localparam logic [3:0]  CTRL_RST        = 4'h9;

	// alarm / interrupt bit positions
	localparam int          AL_ENCAP        = 0;
	localparam int          AL_PLM          = 1;
	localparam int          AL_EXC          = 2;
	localparam int          AL_RFI_RX       = 3;
	localparam int          AL_TIM          = 4;
	localparam int          N_EVT           = 5;
	localparam int          AL_RFI_TX       = 5;
	localparam int          AL_LINK_DOWN    = 6;

	// signal label codes
	localparam logic [7:0]  C2_UNEQUIPPED   = 8'h00;
	localparam logic [7:0]  C2_EQUIP_UNSPEC = 8'h01;
	localparam logic [7:0]  C2_GFP          = 8'h1B;
	localparam logic [7:0]  C2_PDI_LO       = 8'hE1;
	localparam logic [7:0]  C2_PDI_HI       = 8'hFC;
	localparam logic [7:0]  EXP_C2_RST      = 8'h01;

	localparam logic [15:0] EXC_THR_RST     = 16'h0064;
	localparam int          HYST_DIV        = 10;
	// one second of 125 us frames
	localparam int          WINDOW_FRAMES   = 8000;

	localparam int          J1_LEN          = 16;
	localparam int          J1_IDX_W        = 4;

endpackage : path_mon_pkg

// File: verilog/trace_mem.sv
/*
 * Expected path trace store: 16 bytes, one write port, one registered
 * read port. Assumes a single clock and that the writer owns the address.
 */
`timescale 1ns/1ps
`default_nettype none

module trace_mem
	import path_mon_pkg::*;
(
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                wr_en,
	input  wire logic [J1_IDX_W-1:0] wr_addr,
	input  wire logic [7:0]          wr_data,
	input  wire logic [J1_IDX_W-1:0] rd_addr,
	output var  logic [7:0]          rd_data
);

	logic [7:0] mem_r [J1_LEN];

	always_ff @(posedge pclk) begin
		if (wr_en) begin
			mem_r[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_data <= 8'h00;
		end else begin
			rd_data <= mem_r[rd_addr];
		end
	end

endmodule : trace_mem

`default_nettype wire

// File: tb/path_mon_assertions.sv
/* Port-level checks for the path alarm monitor.
 * Assumes one clock pclk and asynchronous active-low presetn. */
`timescale 1ns/1ps
`default_nettype none
module path_mon_assertions (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        persist_fail,
	input wire logic [7:0]  tx_c2_label,
	input wire logic        protect_switch,
	input wire logic        path_remote_fail_ind_tx,
	input wire logic        tim_critical,
	input wire logic        tim_minor
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence setup_s;
		psel && !penable ##1 psel && penable;
	endsequence
	sequence answer_s;
		!pready ##1 pready ##1 !pready;
	endsequence
	a_apb_one_wait: assert property (setup_s |-> answer_s)
		else $error("apb answer not after one wait state");
	a_ready_needs_access: assert property (pready |-> $past(psel && penable))
		else $error("pready without access phase");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr outside pready");
	a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
		else $error("prdata not zero outside answer");
	a_tx_label_code: assert property (tx_c2_label == 8'h01 || tx_c2_label == 8'h1B)
		else $error("sent label is neither code");
	a_rfi_follows_fail: assert property (path_remote_fail_ind_tx == $past(persist_fail))
		else $error("remote fail indication not sent with failure");
	a_rfi_clears: assert property ($fell(persist_fail) |=> !path_remote_fail_ind_tx)
		else $error("remote fail indication stuck");
	a_switch_on_fail: assert property (persist_fail |=> protect_switch)
		else $error("no protection switch on failure");
	a_tim_one_grade: assert property (!(tim_critical && tim_minor))
		else $error("trace mismatch graded twice");
endmodule : path_mon_assertions
bind path_alarm_monitor path_mon_assertions u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.persist_fail(persist_fail), .tx_c2_label(tx_c2_label), .protect_switch(protect_switch),
	.path_remote_fail_ind_tx(path_remote_fail_ind_tx), .tim_critical(tim_critical),
	.tim_minor(tim_minor));
`default_nettype wire

// File: tb/path_far_end.sv
/* Far path end: sends labels, frame error counts, trace bytes, remote fail.
 * Assumes the caller runs its tasks from one process at a time. */
`timescale 1ns/1ps
`default_nettype none
module path_far_end (
	input  wire logic       pclk,
	output var  logic       c2_valid,
	output var  logic [7:0] c2_rx,
	output var  logic       frame_tick,
	output var  logic [3:0] b3_err_inc,
	output var  logic       j1_valid,
	output var  logic       j1_start,
	output var  logic [7:0] j1_rx,
	output var  logic       rfi_rx
);
	initial begin
		c2_valid = 0; c2_rx = 8'hA5; frame_tick = 0; b3_err_inc = 4'hA;
		j1_valid = 0; j1_start = 0; j1_rx = 8'h5A; rfi_rx = 0;
	end
	// label reflects far framing choice; a disagreeing end shows here
	task send_label(input logic [7:0] v);
		@(posedge pclk); c2_valid <= 1; c2_rx <= v;
		@(posedge pclk); c2_valid <= 0; c2_rx <= ~v;
	endtask : send_label
	task frame(input logic [3:0] e, input int gap);
		repeat (gap) @(posedge pclk);
		@(posedge pclk); frame_tick <= 1; b3_err_inc <= e;
		@(posedge pclk); frame_tick <= 0; b3_err_inc <= ~e;
	endtask : frame
	// bad = 16 sends a clean trace
	task trace(input int bad);
		for (int i = 0; i < 16; i++) begin
			@(posedge pclk); j1_valid <= 1; j1_start <= (i == 0);
			j1_rx <= 8'h30 + 8'(i) + 8'(i == bad);
		end
		@(posedge pclk); j1_valid <= 0; j1_start <= 0; j1_rx <= ~j1_rx;
	endtask : trace
	task remote_fail(input logic v);
		@(posedge pclk); rfi_rx <= v;
	endtask : remote_fail
endmodule : path_far_end
`default_nettype wire

// File: tb/test_path_alarm_monitor.sv
/* Register-level test of the path alarm monitor against a far-end model.
 * Assumes a 4-frame error window so every count is reached quickly. */
`timescale 1ns/1ps
`default_nettype none
module test_path_alarm_monitor;
	import path_mon_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, persist_fail, er;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic        pready, pslverr, c2_valid, frame_tick, j1_valid, j1_start, rfi_rx;
	logic [7:0]  c2_rx, j1_rx, tx_c2_label;
	logic [3:0]  b3_err_inc;
	logic        link_down, protect_switch, rfi_tx, tim_critical, tim_minor, irq;
	logic [1:0]  e;
	logic [23:0] paddr_hi = 24'h000000;
	int          miscompares = 0, check_count = 0, cycles = 0;
	logic [15:0] lbl [10] = '{16'h011B, 16'h0100, 16'h01E1, 16'h01FC, 16'h0101,
		16'h1B01, 16'h1B1B, 16'h1B05, 16'h1B1B, 16'h1B01};
	logic [7:0]  win [4] = '{8'h54, 8'h55, 8'h10, 8'h02};
	int          sum [4] = '{19, 20, 3, 2};
	logic        exc [4] = '{0, 1, 1, 0};
	initial begin
		pclk = 0;
		forever #2 pclk = ~pclk;
	end
	path_alarm_monitor #(.WINDOW(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .c2_valid(c2_valid),
		.c2_rx(c2_rx), .frame_tick(frame_tick), .b3_err_inc(b3_err_inc),
		.j1_valid(j1_valid), .j1_start(j1_start), .j1_rx(j1_rx),
		.persist_fail(persist_fail), .rfi_rx(rfi_rx), .tx_c2_label(tx_c2_label),
		.link_down(link_down), .protect_switch(protect_switch),
		.path_remote_fail_ind_tx(rfi_tx), .tim_critical(tim_critical),
		.tim_minor(tim_minor), .irq(irq));
	path_far_end far (.pclk(pclk), .c2_valid(c2_valid), .c2_rx(c2_rx),
		.frame_tick(frame_tick), .b3_err_inc(b3_err_inc), .j1_valid(j1_valid),
		.j1_start(j1_start), .j1_rx(j1_rx), .rfi_rx(rfi_rx));
	////////////////////////////////////////////////////////////////////////////////
	task finish_test;
		if (miscompares == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : finish_test
	task chk(input string n, input logic [31:0] x, input logic [31:0] g);
		check_count++;
		if (g !== x) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", n, x, g);
		end
	endtask : chk
	// the edge wait at entry keeps release and next setup apart
	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk); psel <= 1; penable <= 0; pwrite <= w; paddr <= {paddr_hi, a}; pwdata <= d;
		@(posedge pclk); penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata; er = pslverr; psel <= 0; penable <= 0;
	endtask : apb
	task rdchk(input string n, input logic [7:0] a, input logic [31:0] x);
		apb(a, 0, 32'h0); chk(n, x, rd);
	endtask : rdchk
	function automatic logic [1:0] label_exp(input logic [7:0] x, input logic [7:0] r);
		logic v, u;
		v = r != C2_UNEQUIPPED && !(r >= C2_PDI_LO && r <= C2_PDI_HI) && r != x;
		u = r == C2_EQUIP_UNSPEC || x == C2_EQUIP_UNSPEC;
		return {v && !u, v && u};
	endfunction : label_exp
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			finish_test;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; persist_fail = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1;
		rdchk("ctrl", ADDR_CTRL, 32'h9);
		rdchk("exp_c2", ADDR_EXP_C2, 32'h1);
		rdchk("thr", ADDR_EXC_THR, 32'h64);
		rdchk("int_mask", ADDR_INT_MASK, 32'h0);
		chk("tx_label", 32'h01, {24'h0, tx_c2_label});
		for (int i = 0; i < 10; i++) begin
			apb(ADDR_EXP_C2, 1, {24'h0, lbl[i][15:8]});
			far.send_label(lbl[i][7:0]);
			e = label_exp(lbl[i][15:8], lbl[i][7:0]);
			rdchk("alarm", ADDR_ALARM, {25'h0, e[0], 4'h0, e});
			chk("link_down", {31'h0, e[0]}, {31'h0, link_down});
		end
		apb(ADDR_CTRL, 1, 32'h8);
		repeat (3) @(posedge pclk);
		chk("link_off", 32'h0, {31'h0, link_down});
		rdchk("int_stat", ADDR_INT_STAT, 32'h3);
		chk("irq_masked", 32'h0, {31'h0, irq});
		apb(ADDR_INT_MASK, 1, 32'h1);
		repeat (3) @(posedge pclk);
		chk("irq_on", 32'h1, {31'h0, irq});
		apb(ADDR_INT_STAT, 1, 32'h3);
		repeat (3) @(posedge pclk);
		chk("irq_off", 32'h0, {31'h0, irq});
		rdchk("int_clr", ADDR_INT_STAT, 32'h0);
		apb(8'h20, 0, 32'h0);
		chk("slverr", 32'h1, {31'h0, er});
		chk("bad_rd", 32'h0, rd);
		// an address above the decoded byte must not alias onto a register
		paddr_hi = 24'h000001;
		apb(ADDR_CTRL, 0, 32'h0);
		paddr_hi = 24'h000000;
		chk("slverr_hi", 32'h1, {31'h0, er});
		chk("bad_rd_hi", 32'h0, rd);
		apb(ADDR_EXC_THR, 1, 32'h14);
		for (int i = 0; i < 4; i++) begin
			repeat (3) far.frame(win[i][7:4], i);
			far.frame(win[i][3:0], 0);
			rdchk("err_cnt", ADDR_ERR_CNT, sum[i]);
			apb(ADDR_ALARM, 0, 32'h0);
			chk("exc", {31'h0, exc[i]}, {31'h0, rd[AL_EXC]});
			chk("switch", {31'h0, exc[i]}, {31'h0, protect_switch});
		end
		far.remote_fail(1);
		apb(ADDR_ALARM, 0, 32'h0);
		chk("rfi_rx", 32'h1, {31'h0, rd[AL_RFI_RX]});
		far.remote_fail(0);
		apb(ADDR_ALARM, 0, 32'h0);
		chk("rfi_rx_clr", 32'h0, {31'h0, rd[AL_RFI_RX]});
		@(posedge pclk) persist_fail <= 1;
		repeat (2) @(posedge pclk);
		chk("rfi_tx", 32'h1, {31'h0, rfi_tx});
		chk("switch_fail", 32'h1, {31'h0, protect_switch});
		persist_fail <= 0;
		repeat (2) @(posedge pclk);
		chk("rfi_tx_clr", 32'h0, {31'h0, rfi_tx});
		for (int i = 0; i < 16; i++)
			apb(ADDR_J1_BASE + 8'(4 * i), 1, 32'h30 + i);
		far.trace(16);
		repeat (4) @(posedge pclk);
		chk("tim_clean", 32'h0, {31'h0, tim_critical | tim_minor});
		far.trace(15);
		repeat (4) @(posedge pclk);
		chk("tim_crit", 32'h1, {31'h0, tim_critical});
		rdchk("alarm_tim", ADDR_ALARM, 32'h11);
		apb(ADDR_CTRL, 1, 32'h2);
		repeat (3) @(posedge pclk);
		chk("tim_minor", 32'h1, {31'h0, tim_minor});
		chk("gfp_label", 32'h1B, {24'h0, tx_c2_label});
		far.trace(16);
		repeat (4) @(posedge pclk);
		chk("tim_gone", 32'h0, {31'h0, tim_minor});
		// expected label taken from the framing mode instead of the register
		apb(ADDR_CTRL, 1, 32'h5);
		far.send_label(C2_GFP);
		e = label_exp(C2_EQUIP_UNSPEC, C2_GFP);
		rdchk("alarm_auto", ADDR_ALARM, {25'h0, e[0], 4'h0, e});
		chk("link_on", 32'h1, {31'h0, link_down});
		chk("hdlc_label", 32'h01, {24'h0, tx_c2_label});
		finish_test;
	end
endmodule : test_path_alarm_monitor
`default_nettype wire
